/* File: hw/touch_irq_pkg.sv */
package touch_irq_pkg;
    // ****************************************
    // Register map (printed offsets are indices)
    // ****************************************
    localparam int unsigned REG_INDEX_PIN_CONFIG = 32'h0000_0009;
    localparam int unsigned REG_INDEX_IRQ_STATUS = 32'h0000_0043;
    localparam int unsigned REG_INDEX_IRQ_ENABLE = 32'h0000_0050;
    localparam int unsigned REG_INDEX_IRQ_CLEAR  = 32'h0000_0051;
    localparam logic [11:0] ADDR_PIN_CONFIG = 12'(REG_INDEX_PIN_CONFIG * 4);
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'(REG_INDEX_IRQ_STATUS * 4);
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'(REG_INDEX_IRQ_ENABLE * 4);
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'(REG_INDEX_IRQ_CLEAR * 4);
    localparam int unsigned ADDR_WIDTH      = 12;
    localparam int unsigned REG_WIDTH       = 16;

    // ****************************************
    // Fields
    // ****************************************
    localparam int unsigned PIN_MODE_LSB    = 0;
    localparam int unsigned PIN_MODE_MSB    = 1;
    localparam int unsigned TRIG_LSB        = 2;
    localparam int unsigned TRIG_MSB        = 4;
    localparam int unsigned PIN_STATUS_BIT  = 15;
    localparam logic [1:0]  PIN_MODE_INPUT  = 2'h1;
    localparam logic [15:0] PIN_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET    = 16'hFFFF;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        TRIG_NONE    = 3'b000,
        TRIG_LOW     = 3'b001,
        TRIG_HIGH    = 3'b010,
        TRIG_RSVD3   = 3'b011,
        TRIG_RSVD4   = 3'b100,
        TRIG_FALL    = 3'b101,
        TRIG_RISE    = 3'b110,
        TRIG_BOTH    = 3'b111
    } trig_type;
endpackage : touch_irq_pkg

/* File: hw/pin_trigger.sv */
`timescale 1ns/1ns
module pin_trigger (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Pin and setup
    input  wire logic       pin_in,
    input  wire logic       pin_is_input,
    input  wire logic [2:0] trig_sel,
    // Result
    output logic            trig_hit,
    output logic            cond_active
);
    import touch_irq_pkg::*;

    logic sync_a;
    logic sync_b;
    logic prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev   <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            prev   <= sync_b;
        end
    end

    always_comb begin
        trig_hit    = 1'b0;
        cond_active = 1'b0;
        if (pin_is_input) begin
            unique case (trig_type'(trig_sel))
                TRIG_LOW:  cond_active = !sync_b;
                TRIG_HIGH: cond_active = sync_b;
                TRIG_FALL: trig_hit = prev && !sync_b;
                TRIG_RISE: trig_hit = !prev && sync_b;
                TRIG_BOTH: trig_hit = prev ^ sync_b;
                TRIG_NONE, TRIG_RSVD3, TRIG_RSVD4: trig_hit = 1'b0;
            endcase
            trig_hit = trig_hit | cond_active;
        end
    end

    a_level_low_hit: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_is_input && trig_sel == TRIG_LOW && !sync_b) |-> trig_hit)
        else $error("low level did not trigger");
    a_rise_edge_hit: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_is_input && trig_sel == TRIG_RISE && $rose(sync_b)) |-> trig_hit)
        else $error("rising edge missed");
    a_unused_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (trig_sel == TRIG_NONE || trig_sel == TRIG_RSVD3 || trig_sel == TRIG_RSVD4)
        |-> !trig_hit)
        else $error("unused trigger fired");
endmodule : pin_trigger

/* File: hw/touch_irq_ctrl.sv */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// How it works
// - touch and untouch each raise event
// - read releases output, untouch reasserts
// - shield copies active sensor excitation
// - pin mode 01 makes pin interrupt source
// - trigger field selects; 000/011/100 none
// - 001 low level, 010 high level
// - 101 fall, 110 rise, 111 both
// - pin trigger sets status bit 15
// - read clears pin bit if condition gone
// - output active low, strap inverts polarity
// - status bit one on touch, zero untouch
module touch_irq_ctrl
    import touch_irq_pkg::*;
#(
    parameter int unsigned CHANNELS = 8
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_WIDTH-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read
    input  wire logic [ADDR_WIDTH-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Sensor side
    input  wire logic [CHANNELS-1:0]   touch_state,
    input  wire logic [CHANNELS-1:0]   excite_wave,
    input  wire logic [2:0]            active_sensor,
    input  wire logic                  shield_follow,
    // Pins
    input  wire logic                  gp_pin_in,
    input  wire logic                  polarity_strap,
    output logic                       host_interrupt_out,
    output logic                       shield_out
);
    import touch_irq_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [REG_WIDTH-1:0] pin_config;
    logic [REG_WIDTH-1:0] irq_enable;
    logic [CHANNELS-1:0]  touch_status;
    logic [CHANNELS-1:0]  touch_prev;
    logic [CHANNELS-1:0]  touch_event;
    logic                 pin_status;
    logic                 pin_hit;
    logic                 pin_cond;
    logic                 active_high;
    logic                 strap_taken;
    logic                 aw_held;
    logic                 w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 status_read;
    logic                 clear_write;
    logic [REG_WIDTH-1:0] clear_mask;
    logic                 irq_any;
    logic                 next_irq_level;
    logic [REG_WIDTH-1:0] status_word;

    function automatic logic [REG_WIDTH-1:0] read_reg(input logic [ADDR_WIDTH-1:0] a,
            input logic [REG_WIDTH-1:0] cfg, input logic [REG_WIDTH-1:0] st,
            input logic [REG_WIDTH-1:0] en);
        unique case (a)
            ADDR_PIN_CONFIG: read_reg = cfg;
            ADDR_IRQ_STATUS: read_reg = st;
            ADDR_IRQ_ENABLE: read_reg = en;
            default:         read_reg = '0;
        endcase
    endfunction : read_reg

    function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
        is_mapped = (a == ADDR_PIN_CONFIG) || (a == ADDR_IRQ_STATUS)
                 || (a == ADDR_IRQ_ENABLE) || (a == ADDR_IRQ_CLEAR);
    endfunction : is_mapped

    // ****************************************
    // Pin trigger
    // ****************************************
    // pin only counts in input mode
    pin_trigger u_trig (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .pin_in       (gp_pin_in),
        .pin_is_input (pin_config[PIN_MODE_MSB:PIN_MODE_LSB] == PIN_MODE_INPUT),
        .trig_sel     (pin_config[TRIG_MSB:TRIG_LSB]),
        .trig_hit     (pin_hit),
        .cond_active  (pin_cond)
    );

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign status_read = arvalid && arready && (araddr == ADDR_IRQ_STATUS);
    assign clear_write = aw_held && w_held && !bvalid && (aw_addr == ADDR_IRQ_CLEAR);
    assign clear_mask  = clear_write ? w_data[REG_WIDTH-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
                wready <= 1'b0;
            end
            if (aw_held && w_held && !bvalid) begin
                bvalid <= 1'b1;
                bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_config <= PIN_CONFIG_RESET;
            irq_enable <= ENABLE_RESET;
        end else if (aw_held && w_held && !bvalid) begin
            if (aw_addr == ADDR_PIN_CONFIG) begin
                if (w_strb[0]) pin_config[7:0]  <= w_data[7:0];
                if (w_strb[1]) pin_config[15:8] <= w_data[15:8];
            end
            if (aw_addr == ADDR_IRQ_ENABLE) begin
                if (w_strb[0]) irq_enable[7:0]  <= w_data[7:0];
                if (w_strb[1]) irq_enable[15:8] <= w_data[15:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {16'h0000, read_reg(araddr, pin_config, status_word, irq_enable)};
            rresp   <= (is_mapped(araddr) && araddr != ADDR_IRQ_CLEAR)
                       ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ****************************************
    // Status and interrupt
    // ****************************************
    always_comb begin
        status_word = '0;
        status_word[CHANNELS-1:0] = touch_status;
        status_word[PIN_STATUS_BIT] = pin_status;
    end

    assign touch_event = touch_state ^ touch_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            touch_prev   <= '0;
            touch_status <= '0;
        end else begin
            touch_prev   <= touch_state;
            touch_status <= touch_state;
        end
    end

    // pin hit sets bit 15; set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_status <= 1'b0;
        end else if (pin_hit) begin
            pin_status <= 1'b1;
        end else if ((status_read || clear_mask[PIN_STATUS_BIT]) && !pin_cond) begin
            pin_status <= 1'b0;
        end
    end

    // each touch and untouch is an event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_any <= 1'b0;
        end else if (|(touch_event & irq_enable[CHANNELS-1:0])
                     || (pin_hit && irq_enable[PIN_STATUS_BIT])) begin
            irq_any <= 1'b1;
        end else if (status_read || clear_write) begin
            irq_any <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken <= 1'b0;
            active_high <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            active_high <= polarity_strap;
        end
    end

    assign next_irq_level = irq_any || (pin_status && irq_enable[PIN_STATUS_BIT]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_interrupt_out <= 1'b1;
        end else begin
            host_interrupt_out <= next_irq_level ~^ active_high;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shield_out <= 1'b0;
        end else begin
            shield_out <= shield_follow ? excite_wave[active_sensor] : 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_touch_raises_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(touch_event & irq_enable[CHANNELS-1:0])) |=> irq_any)
        else $error("touch event lost");
    a_read_releases: assert property (@(posedge aclk) disable iff (!aresetn)
        (status_read && touch_event == '0 && !pin_hit && !pin_status) |=> ##1
        (host_interrupt_out == !active_high))
        else $error("read did not release interrupt");
    a_pin_sets_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_hit |=> pin_status)
        else $error("pin status not set");
    a_pin_hold_cond: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_status && pin_cond) |=> pin_status)
        else $error("pin status cleared while condition present");
    a_status_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> touch_status == $past(touch_state))
        else $error("touch status wrong");
    a_shield_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        shield_follow |=> shield_out == $past(excite_wave[active_sensor]))
        else $error("shield not following");
    a_out_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        strap_taken |=> host_interrupt_out == ($past(next_irq_level) ~^ $past(active_high)))
        else $error("interrupt polarity wrong");
    a_mode_gates_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_config[PIN_MODE_MSB:PIN_MODE_LSB] != PIN_MODE_INPUT) |-> !pin_hit)
        else $error("pin triggered outside input mode");

    c_touch: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_any));
    c_read_clear: cover property (@(posedge aclk) disable iff (!aresetn)
        irq_any ##1 status_read ##2 !irq_any);
    c_pin: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pin_status));
endmodule : touch_irq_ctrl

/* File: sim/axi_host_model.sv */
`timescale 1ns/1ns
module axi_host_model (
    // Clock and interrupt pin
    input  wire logic                            aclk,
    input  wire logic                            host_interrupt_out,
    // Write channels
    output logic [touch_irq_pkg::ADDR_WIDTH-1:0] awaddr,
    output logic                                 awvalid,
    input  wire logic                            awready,
    output logic [31:0]                          wdata,
    output logic [3:0]                           wstrb,
    output logic                                 wvalid,
    input  wire logic                            wready,
    input  wire logic [1:0]                      bresp,
    input  wire logic                            bvalid,
    output logic                                 bready,
    // Read channels
    output logic [touch_irq_pkg::ADDR_WIDTH-1:0] araddr,
    output logic                                 arvalid,
    input  wire logic                            arready,
    input  wire logic [31:0]                     rdata,
    input  wire logic [1:0]                      rresp,
    input  wire logic                            rvalid,
    output logic                                 rready,
    // Raised when a wait runs out
    output logic                                 hang
);
    import touch_irq_pkg::*;
    // ****************************************
    // Master tasks
    // ****************************************
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, hang} = 6'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
    end

    task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [15:0] d,
                      output logic [1:0] resp);
        logic done;
        done = 1'b0;
        resp = 2'h3;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'h7;
        // Local flag: the cleared bready is not visible until this step ends
        for (int n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        // One spare edge so a following call never drives the same step
        if (done) begin
            @(posedge aclk);
        end else begin
            hang <= 1'b1;
        end
    endtask : wr

    task automatic rd(input logic [ADDR_WIDTH-1:0] a, output logic [31:0] data,
                      output logic [1:0] resp);
        logic done;
        done = 1'b0;
        data = 32'hDEAD_BEEF;
        resp = 2'h3;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (int n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (done) begin
            @(posedge aclk);
        end else begin
            hang <= 1'b1;
        end
    endtask : rd

    task automatic serve(input logic act, output logic [31:0] data);
        logic [1:0] resp;
        for (int n = 0; n < 40 && host_interrupt_out !== act; n++) @(posedge aclk);
        if (host_interrupt_out !== act) hang <= 1'b1;
        rd(ADDR_IRQ_STATUS, data, resp);
    endtask : serve
endmodule : axi_host_model

/* File: sim/touch_gpio_interrupt_logic_bench.sv */
`timescale 1ns/1ns
module touch_gpio_interrupt_logic_bench;
    import touch_irq_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, data;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, hang, host_interrupt_out, shield_out;
    logic [7:0]  touch_state = 8'h00, excite_wave = 8'h00;
    logic [2:0]  active_sensor = 3'h0;
    logic        shield_follow = 1'b0, gp_pin_in = 1'b0, polarity_strap = 1'b0;
    int          errors = 0, total_checks = 0;

    always #25 aclk = ~aclk;

    touch_irq_ctrl #(.CHANNELS(8)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .touch_state(touch_state), .excite_wave(excite_wave),
        .active_sensor(active_sensor), .shield_follow(shield_follow),
        .gp_pin_in(gp_pin_in), .polarity_strap(polarity_strap),
        .host_interrupt_out(host_interrupt_out), .shield_out(shield_out));

    axi_host_model host (.aclk(aclk), .host_interrupt_out(host_interrupt_out),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .hang(hang));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        host.rd(a, data, resp);
        check(data, exp);
        check({30'h0, resp}, {30'h0, er});
    endtask : rd_chk

    task automatic do_reset(input logic strap);
        aresetn <= 1'b0;
        polarity_strap <= strap;
        tick(20);
        aresetn <= 1'b1;
        tick(4);
    endtask : do_reset

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        rd_chk(ADDR_PIN_CONFIG, {16'h0000, PIN_CONFIG_RESET}, RESP_OKAY);
        rd_chk(ADDR_IRQ_ENABLE, {16'h0000, ENABLE_RESET}, RESP_OKAY);
        rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
        rd_chk(12'h000, 32'h0000_0000, RESP_SLVERR);
        rd_chk(ADDR_IRQ_CLEAR, 32'h0000_0000, RESP_SLVERR);
        host.wr(12'h004, 16'hFFFF, resp);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        host.wr(ADDR_PIN_CONFIG, 16'h001D, resp);
        rd_chk(ADDR_PIN_CONFIG, 32'h0000_001D, RESP_OKAY);
        check({31'h0, host_interrupt_out}, 32'h1);
    endtask : t_regs

    task automatic t_touch;
        touch_state <= 8'h04;
        host.serve(1'b0, data);
        check(data, 32'h0000_0004);
        tick(3);
        check({31'h0, host_interrupt_out}, 32'h1);
        touch_state <= 8'h00;
        host.serve(1'b0, data);
        check(data, 32'h0000_0000);
        tick(3);
        check({31'h0, host_interrupt_out}, 32'h1);
    endtask : t_touch

    task automatic t_clear_mask;
        touch_state <= 8'h01;
        tick(4);
        check({31'h0, host_interrupt_out}, 32'h0);
        host.wr(ADDR_IRQ_CLEAR, 16'hFFFF, resp);
        tick(3);
        check({31'h0, host_interrupt_out}, 32'h1);
        host.wr(ADDR_IRQ_ENABLE, 16'h0000, resp);
        touch_state <= 8'h00;
        tick(8);
        check({31'h0, host_interrupt_out}, 32'h1);
        host.wr(ADDR_IRQ_ENABLE, 16'hFFFF, resp);
        host.rd(ADDR_IRQ_STATUS, data, resp);
        tick(3);
        check({31'h0, host_interrupt_out}, 32'h1);
    endtask : t_clear_mask

    // Status reads twice: first shows the latch, second whether a level still holds
    task automatic pin_case(input logic [1:0] mode, input logic [2:0] trig,
                            input logic s, input logic a, input logic lvl, input logic b);
        host.wr(ADDR_PIN_CONFIG, 16'h0000, resp);
        gp_pin_in <= s;
        tick(6);
        host.wr(ADDR_PIN_CONFIG, {11'h000, trig, mode}, resp);
        tick(6);
        host.rd(ADDR_IRQ_STATUS, data, resp);
        gp_pin_in <= ~s;
        tick(8);
        check({31'h0, host_interrupt_out}, {31'h0, ~a});
        rd_chk(ADDR_IRQ_STATUS, {16'h0, a, 15'h0}, RESP_OKAY);
        rd_chk(ADDR_IRQ_STATUS, {16'h0, lvl, 15'h0}, RESP_OKAY);
        gp_pin_in <= s;
        tick(8);
        rd_chk(ADDR_IRQ_STATUS, {16'h0, b, 15'h0}, RESP_OKAY);
        rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
        tick(3);
        check({31'h0, host_interrupt_out}, 32'h1);
    endtask : pin_case

    task automatic t_pin;
        logic [7:0] hit_a, hit_l, hit_b;
        hit_a = 8'hC6;
        hit_l = 8'h06;
        hit_b = 8'hA6;
        for (int i = 0; i < 8; i++) begin
            pin_case(PIN_MODE_INPUT, 3'(i), (i == 1), hit_a[i], hit_l[i], hit_b[i]);
        end
        pin_case(2'h0, TRIG_RISE, 1'b0, 1'b0, 1'b0, 1'b0);
        pin_case(2'h2, TRIG_BOTH, 1'b0, 1'b0, 1'b0, 1'b0);
        pin_case(2'h3, TRIG_BOTH, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask : t_pin

    task automatic t_shield;
        logic [7:0] wave;
        wave = 8'hA5;
        shield_follow <= 1'b1;
        excite_wave <= wave;
        for (int i = 0; i < 8; i++) begin
            active_sensor <= 3'(i);
            tick(3);
            check({31'h0, shield_out}, {31'h0, wave[i]});
        end
        shield_follow <= 1'b0;
        tick(3);
        check({31'h0, shield_out}, 32'h0);
    endtask : t_shield

    task automatic t_polarity;
        do_reset(1'b1);
        check({31'h0, host_interrupt_out}, 32'h0);
        touch_state <= 8'h80;
        host.serve(1'b1, data);
        check(data, 32'h0000_0080);
        tick(3);
        check({31'h0, host_interrupt_out}, 32'h0);
    endtask : t_polarity

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    always @(posedge hang) begin
        errors++;
        end_of_test;
    end

    initial begin
        do_reset(1'b0);
        t_regs;
        t_touch;
        t_clear_mask;
        t_pin;
        t_shield;
        t_polarity;
        end_of_test;
    end
endmodule : touch_gpio_interrupt_logic_bench
